// >>> design/piehe_pkg.sv
/*
 * Package of the protocol interrupt enable and host-interface error flag block:
 * register offsets, field positions, reset values and the bus carrier structs.
 * Assumes a 32-bit Avalon-MM slave with word-aligned byte addresses.
 */
`default_nettype none
package piehe_pkg;
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] OFS_PROTO_EN0 = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_PROTO_EN1 = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_ERR_FLAGS = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_GLOBAL_EN = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_IRQ_CLEAR = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_PROTO_FLAGS = 8'h1C;
    localparam logic [15:0] RST_PROTO_EN0 = 16'h0000;
    localparam logic [15:0] RST_PROTO_EN1 = 16'h0000;
    localparam logic [15:0] RST_ERR_FLAGS = 16'h0000;
    localparam logic RST_HOST_IF_EN = 1'b0;
    // protocol enable 1 positions, matching protocol flag register 1
    localparam int BIT_ODD_TABLE = 0;
    localparam int BIT_EVEN_TABLE = 1;
    localparam int BIT_SLOT_CNT0 = 4;
    localparam int BIT_STATE_CHG = 8;
    localparam int BIT_ENGINE_FAIL = 9;
    localparam int BIT_ILLEGAL_CMD = 10;
    localparam int BIT_ERR_MODE = 15;
    localparam logic [15:0] PROTO1_IMPL_MASK = 16'h87F3;
    // error flag positions
    localparam int BIT_BUF_SEARCH = 9;
    localparam int BIT_OVR_A = 10;
    localparam int BIT_OVR_B = 11;
    localparam int BIT_CMD_IGN = 13;
    localparam int BIT_LOST_A = 14;
    localparam int BIT_LOST_B = 15;
    localparam logic [15:0] ERR_IMPL_MASK = 16'hEE00;
    localparam int BIT_GLOBAL_HOST_EN = 0;
    // own status events: 0 proto request rose, 1 host-if request rose
    localparam int NUM_EVT = 2;
    localparam logic [7:0] MAX_BUF_INDEX = 8'd131;
    typedef struct packed {
        logic read;
        logic write;
        logic [ADDR_W-1:0] address;
        logic [31:0] writedata;
    } piehe_bus_req_t;
    typedef struct packed {
        logic waitrequest;
        logic [31:0] readdata;
    } piehe_bus_rsp_t;
endpackage : piehe_pkg
`default_nettype wire

// >>> design/piehe_top.sv
/*
 * Protocol interrupt enables, host-interface error flags, and own event status.
 * Assumes all event inputs are one-cycle pulses synchronous to ref_clk and the
 * protocol flag registers are supplied as levels from outside.
 */
`timescale 1ns/1ps
`default_nettype none
module piehe_top #(
    parameter int NUM_SHADOW = 4
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire piehe_pkg::piehe_bus_req_t avs_req,
    output piehe_pkg::piehe_bus_rsp_t avs_rsp,
    input wire logic [15:0] protocol_flag_reg_0,
    input wire logic [15:0] protocol_flag_reg_1,
    input wire logic frame_lost_a_evt,
    input wire logic frame_lost_b_evt,
    input wire logic command_write,
    input wire logic command_pending_flag,
    input wire logic rx_fifo_overrun_a_evt,
    input wire logic rx_fifo_overrun_b_evt,
    input wire logic search_busy,
    input wire logic search_start,
    input wire logic found_valid,
    input wire logic [7:0] found_buffer_index,
    input wire logic [NUM_SHADOW*8-1:0] shadow_buffer_index,
    output logic command_accept,
    output logic protocol_irq,
    output logic host_if_irq,
    output logic irq
);
    import piehe_pkg::*;

    initial begin
        if (NUM_SHADOW < 1 || NUM_SHADOW > 8) begin
            $error("NUM_SHADOW out of range");
        end
    end

    typedef struct packed {
        logic [15:0] en0;
        logic [15:0] en1;
        logic [15:0] err;
        logic host_en;
        logic [NUM_EVT-1:0] sts;
        logic [NUM_EVT-1:0] ien;
        logic proto_prev;
        logic host_prev;
        logic ack;
        logic [31:0] rdata;
    } piehe_state_t;

    piehe_state_t s_q, s_d;

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    logic [NUM_SHADOW-1:0] shadow_bad;
    genvar gi;
    generate
        for (gi = 0; gi < NUM_SHADOW; gi++) begin : g_shadow
            assign shadow_bad[gi] = shadow_buffer_index[gi*8 +: 8] > MAX_BUF_INDEX;
        end
    endgenerate

    logic [15:0] err_set;
    logic proto_req;
    logic host_req;
    logic acc;
    logic wr_acc;
    logic rd_acc;
    logic [NUM_EVT-1:0] evt;

    always_comb begin
        err_set = 16'h0000;
        err_set[BIT_LOST_B] = frame_lost_b_evt;
        err_set[BIT_LOST_A] = frame_lost_a_evt;
        err_set[BIT_CMD_IGN] = command_write & command_pending_flag;
        err_set[BIT_OVR_B] = rx_fifo_overrun_b_evt;
        err_set[BIT_OVR_A] = rx_fifo_overrun_a_evt;
        err_set[BIT_BUF_SEARCH] = (search_busy & search_start)
            | (found_valid & (found_buffer_index > MAX_BUF_INDEX)) | (|shadow_bad);
    end

    // dropped commands never reach the protocol engine
    assign command_accept = command_write & ~command_pending_flag;

    assign proto_req = |(protocol_flag_reg_0 & s_q.en0)
        | |(protocol_flag_reg_1 & s_q.en1 & PROTO1_IMPL_MASK);
    assign host_req = s_q.host_en & (|s_q.err);
    assign evt = {host_req & ~s_q.host_prev, proto_req & ~s_q.proto_prev};

    // single-cycle wait state so read data comes from a flop
    assign acc = (avs_req.read | avs_req.write) & s_q.ack;
    assign wr_acc = avs_req.write & ~s_q.ack;
    assign rd_acc = avs_req.read & ~s_q.ack;

    always_comb begin
        s_d = s_q;
        s_d.ack = (avs_req.read | avs_req.write) & ~s_q.ack;
        s_d.proto_prev = proto_req;
        s_d.host_prev = host_req;
        // clear first, then set, so a same-cycle event survives
        if (wr_acc && hit(avs_req.address, OFS_ERR_FLAGS)) begin
            s_d.err = s_q.err & ~(avs_req.writedata[15:0] & ERR_IMPL_MASK);
        end
        s_d.err = s_d.err | err_set;
        if (wr_acc && hit(avs_req.address, OFS_IRQ_CLEAR)) begin
            s_d.sts = s_q.sts & ~avs_req.writedata[NUM_EVT-1:0];
        end
        s_d.sts = s_d.sts | evt;
        if (wr_acc) begin
            if (hit(avs_req.address, OFS_PROTO_EN0)) begin
                s_d.en0 = avs_req.writedata[15:0];
            end
            if (hit(avs_req.address, OFS_PROTO_EN1)) begin
                s_d.en1 = avs_req.writedata[15:0] & PROTO1_IMPL_MASK;
            end
            if (hit(avs_req.address, OFS_GLOBAL_EN)) begin
                s_d.host_en = avs_req.writedata[BIT_GLOBAL_HOST_EN];
            end
            if (hit(avs_req.address, OFS_IRQ_ENABLE)) begin
                s_d.ien = avs_req.writedata[NUM_EVT-1:0];
            end
        end
        s_d.rdata = 32'h0000_0000;
        if (rd_acc) begin
            case (avs_req.address)
                OFS_PROTO_EN0: s_d.rdata = {16'h0000, s_q.en0};
                OFS_PROTO_EN1: s_d.rdata = {16'h0000, s_q.en1};
                OFS_ERR_FLAGS: s_d.rdata = {16'h0000, s_q.err};
                OFS_GLOBAL_EN: s_d.rdata = {31'h0000_0000, s_q.host_en};
                OFS_IRQ_STATUS: s_d.rdata = {30'h0000_0000, s_q.sts};
                OFS_IRQ_ENABLE: s_d.rdata = {30'h0000_0000, s_q.ien};
                OFS_PROTO_FLAGS: s_d.rdata = {protocol_flag_reg_1, protocol_flag_reg_0};
                default: s_d.rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s_q.en0 <= RST_PROTO_EN0;
            s_q.en1 <= RST_PROTO_EN1;
            s_q.err <= RST_ERR_FLAGS;
            s_q.host_en <= RST_HOST_IF_EN;
            s_q.sts <= '0;
            s_q.ien <= '0;
            s_q.proto_prev <= 1'b0;
            s_q.host_prev <= 1'b0;
            s_q.ack <= 1'b0;
            s_q.rdata <= 32'h0000_0000;
        end else begin
            s_q <= s_d;
        end
    end

    assign avs_rsp.waitrequest = (avs_req.read | avs_req.write) & ~acc;
    assign avs_rsp.readdata = s_q.rdata;
    assign protocol_irq = proto_req;
    assign host_if_irq = host_req;
    assign irq = |(s_q.sts & s_q.ien);

    AST_EN0_GATE: assert property (@(posedge ref_clk) disable iff (rst)
        (s_q.en0 == 16'h0000 && s_q.en1 == 16'h0000) |-> !protocol_irq)
        else $error("protocol request without any enable");
    AST_EN0_PASS: assert property (@(posedge ref_clk) disable iff (rst)
        |(protocol_flag_reg_0 & s_q.en0) |-> protocol_irq)
        else $error("enabled flag-0 bit did not raise request");
    AST_EN1_PASS: assert property (@(posedge ref_clk) disable iff (rst)
        (protocol_flag_reg_1[BIT_ERR_MODE] && s_q.en1[BIT_ERR_MODE]) |-> protocol_irq)
        else $error("error mode change not passed");
    AST_SLOT_PASS: assert property (@(posedge ref_clk) disable iff (rst)
        |(protocol_flag_reg_1[BIT_SLOT_CNT0 +: 4] & s_q.en1[BIT_SLOT_CNT0 +: 4]) |-> protocol_irq)
        else $error("slot counter flag not passed");
    AST_HOST_EN: assert property (@(posedge ref_clk) disable iff (rst)
        host_if_irq |-> (s_q.host_en && s_q.err != 16'h0000))
        else $error("host interrupt without enable or flag");
    AST_LOST_B: assert property (@(posedge ref_clk) disable iff (rst)
        frame_lost_b_evt |=> s_q.err[BIT_LOST_B])
        else $error("channel B lost flag not set");
    AST_LOST_A: assert property (@(posedge ref_clk) disable iff (rst)
        frame_lost_a_evt |=> s_q.err[BIT_LOST_A])
        else $error("channel A lost flag not set");
    AST_CMD_IGN: assert property (@(posedge ref_clk) disable iff (rst)
        (command_write && command_pending_flag) |-> !command_accept ##1 s_q.err[BIT_CMD_IGN])
        else $error("busy command not dropped and flagged");
    AST_OVR: assert property (@(posedge ref_clk) disable iff (rst)
        rx_fifo_overrun_b_evt |=> s_q.err[BIT_OVR_B])
        else $error("channel B overrun flag not set");
    AST_OVR_A: assert property (@(posedge ref_clk) disable iff (rst)
        rx_fifo_overrun_a_evt |=> s_q.err[BIT_OVR_A])
        else $error("channel A overrun flag not set");
    AST_SEARCH: assert property (@(posedge ref_clk) disable iff (rst)
        ((search_busy && search_start) || (|shadow_bad)) |=> s_q.err[BIT_BUF_SEARCH])
        else $error("search error not set");
    AST_STICKY: assert property (@(posedge ref_clk) disable iff (rst)
        (s_q.err[BIT_LOST_A] && !(wr_acc && hit(avs_req.address, OFS_ERR_FLAGS)
        && avs_req.writedata[BIT_LOST_A])) |=> s_q.err[BIT_LOST_A])
        else $error("error flag dropped without clear");

    AST_FOUND_IDX: assert property (@(posedge ref_clk) disable iff (rst)
        (found_valid && found_buffer_index > MAX_BUF_INDEX)
        |=> s_q.err[BIT_BUF_SEARCH])
        else $error("bad found index not flagged");
    AST_BUSY_SEARCH: assert property (@(posedge ref_clk) disable iff (rst)
        (search_busy && search_start)
        |=> s_q.err[BIT_BUF_SEARCH])
        else $error("busy search start not flagged");
    AST_CMD_PASS: assert property (@(posedge ref_clk) disable iff (rst)
        (command_write && !command_pending_flag)
        |-> command_accept)
        else $error("idle-time command not passed on");

    // set must win over a same-cycle software clear
    AST_SET_WINS: assert property (@(posedge ref_clk) disable iff (rst)
        (frame_lost_b_evt && wr_acc && hit(avs_req.address, OFS_ERR_FLAGS)
        && avs_req.writedata[BIT_LOST_B])
        |=> s_q.err[BIT_LOST_B])
        else $error("same-cycle event lost to clear");

    AST_PROTO_QUIET: assert property (@(posedge ref_clk) disable iff (rst)
        ((protocol_flag_reg_0 & s_q.en0) == 16'h0000
        && (protocol_flag_reg_1 & s_q.en1) == 16'h0000)
        |-> !protocol_irq)
        else $error("protocol request with no enabled flag");
    AST_EN1_MASK: assert property (@(posedge ref_clk) disable iff (rst)
        (s_q.en1 & ~PROTO1_IMPL_MASK) == 16'h0000)
        else $error("unimplemented enable-1 bit set");
    AST_HOST_PASS: assert property (@(posedge ref_clk) disable iff (rst)
        (s_q.host_en && s_q.err != 16'h0000)
        |-> host_if_irq)
        else $error("enabled error flag gave no host request");
    AST_HOST_OFF: assert property (@(posedge ref_clk) disable iff (rst)
        !s_q.host_en |-> !host_if_irq)
        else $error("host request while host enable off");

    // own status bits latch one cycle after a request rises
    AST_STS_PROTO: assert property (@(posedge ref_clk) disable iff (rst)
        (proto_req && !s_q.proto_prev)
        |=> s_q.sts[0])
        else $error("protocol rise not latched");
    AST_STS_HOST: assert property (@(posedge ref_clk) disable iff (rst)
        (host_req && !s_q.host_prev)
        |=> s_q.sts[1])
        else $error("host rise not latched");

    // bus access: one wait state, then the grant
    sequence seq_req_waiting;
        (avs_req.read || avs_req.write) && avs_rsp.waitrequest;
    endsequence
    sequence seq_req_granted;
        (avs_req.read || avs_req.write) && !avs_rsp.waitrequest;
    endsequence
    AST_ONE_WAIT: assert property (@(posedge ref_clk) disable iff (rst)
        seq_req_waiting |=> seq_req_granted)
        else $error("bus access not granted after one wait state");
    AST_READ_FLAGS: assert property (@(posedge ref_clk) disable iff (rst)
        (rd_acc && hit(avs_req.address, OFS_ERR_FLAGS))
        |=> (avs_rsp.readdata == {16'h0000, $past(s_q.err)}))
        else $error("flag read data wrong");

    // every implemented flag sticks and clears on a one; reserved bits stay zero
    generate
        for (gi = 0; gi < 16; gi++) begin : g_err_bit
            if (ERR_IMPL_MASK[gi]) begin : g_impl
                AST_FLAG_HOLD: assert property (@(posedge ref_clk) disable iff (rst)
                    (s_q.err[gi] && !(wr_acc && hit(avs_req.address, OFS_ERR_FLAGS)
                    && avs_req.writedata[gi]))
                    |=> s_q.err[gi])
                    else $error("error flag lost without a one written");
                AST_FLAG_CLEAR: assert property (@(posedge ref_clk) disable iff (rst)
                    (wr_acc && hit(avs_req.address, OFS_ERR_FLAGS)
                    && avs_req.writedata[gi] && !err_set[gi])
                    |=> !s_q.err[gi])
                    else $error("error flag not cleared by a one");
            end else begin : g_unimpl
                AST_FLAG_RSVD: assert property (@(posedge ref_clk) disable iff (rst)
                    !s_q.err[gi])
                    else $error("reserved error flag bit set");
            end
        end
    endgenerate
endmodule : piehe_top
`default_nettype wire

// >>> dv/piehe_test.sv
/*
 * Self-checking bench for the protocol interrupt enable and host error flag block.
 * Assumes piehe_pkg and piehe_top are compiled first; drives every port itself.
 */
`timescale 1ns/1ps
`default_nettype none
module protocol_irq_enable_and_host_error_flags_test;
    import piehe_pkg::*;
    logic ref_clk, rst, cmd_pend, s_busy, cmd_acc, p_irq, h_irq, irq;
    piehe_bus_req_t req;
    piehe_bus_rsp_t rsp;
    logic [15:0] pf0, pf1, e0, e1, ef;
    logic [6:0] ev;
    logic [7:0] f_idx;
    logic [31:0] shadow;
    logic [31:0] exp_q[$];
    int n_fail, tests_run;
    int eb[6] = '{BIT_LOST_A, BIT_LOST_B, BIT_OVR_A, BIT_OVR_B, BIT_CMD_IGN, BIT_BUF_SEARCH};
    piehe_top #(.NUM_SHADOW(4)) uut (.ref_clk(ref_clk), .rst(rst), .avs_req(req), .avs_rsp(rsp),
        .protocol_flag_reg_0(pf0), .protocol_flag_reg_1(pf1), .frame_lost_a_evt(ev[0]),
        .frame_lost_b_evt(ev[1]), .rx_fifo_overrun_a_evt(ev[2]), .rx_fifo_overrun_b_evt(ev[3]),
        .command_write(ev[4]), .command_pending_flag(cmd_pend), .search_busy(s_busy),
        .search_start(ev[5]), .found_valid(ev[6]), .found_buffer_index(f_idx),
        .shadow_buffer_index(shadow), .command_accept(cmd_acc), .protocol_irq(p_irq),
        .host_if_irq(h_irq), .irq(irq));
    task automatic fail(input logic [31:0] e, input logic [31:0] g);
        n_fail++;
        $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    endtask : fail
    task automatic cmp_rd(input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) fail(e, g);
    endtask : cmp_rd
    task automatic cmp_lvl(input logic e, input logic g);
        tests_run++;
        if (g !== e) fail({31'h0, e}, {31'h0, g});
    endtask : cmp_lvl
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        req <= '{read: !wr, write: wr, address: a, writedata: d};
        // hold the request until waitrequest is sampled low at a rising edge
        do begin
            @(posedge ref_clk);
            n++;
        end while (rsp.waitrequest !== 1'b0 && n < 40);
        if (n >= 40) fail(32'h0, 32'h1);
        req <= '0;
    endtask : bus
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        exp_q.push_back({16'h0, e});
        bus(1'b0, a, 32'h0);
    endtask : rd
    task automatic pulse(input logic [6:0] v);
        @(posedge ref_clk);
        ev <= v;
        @(negedge ref_clk);
        cmp_lvl(v[4] & !cmd_pend, cmd_acc);
        @(posedge ref_clk);
        ev <= '0;
    endtask : pulse
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : end_of_test
    always @(posedge ref_clk) begin
        if (req.read === 1'b1 && rsp.waitrequest === 1'b0 && exp_q.size() > 0) cmp_rd(exp_q.pop_front(), rsp.readdata);
    end
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    initial begin
        repeat (20000) @(posedge ref_clk);
        n_fail++;
        end_of_test();
    end
    initial begin
        {rst, req, pf0, pf1, ev, cmd_pend, s_busy, f_idx, shadow} = '0;
        rst = 1'b1;
        void'($urandom(28));
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        foreach (eb[i]) rd(8'(i * 4), 16'h0000);
        rd(8'h20, 16'h0000);
        for (int i = 0; i < 16; i++) begin
            e0 = 16'($urandom);
            e1 = 16'($urandom);
            pf0 <= 16'h1 << ($urandom % 16);
            pf1 <= 16'h1 << ($urandom % 16);
            bus(1'b1, OFS_PROTO_EN0, {16'h0, e0});
            bus(1'b1, OFS_PROTO_EN1, {16'h0, e1});
            rd(OFS_PROTO_EN0, e0);
            rd(OFS_PROTO_EN1, e1 & PROTO1_IMPL_MASK);
            exp_q.push_back({pf1, pf0});
            bus(1'b0, OFS_PROTO_FLAGS, 32'h0);
            @(negedge ref_clk);
            cmp_lvl(|(pf0 & e0) | |(pf1 & e1 & PROTO1_IMPL_MASK), p_irq);
        end
        pf0 <= '0;
        pf1 <= '0;
        cmd_pend <= 1'b1;
        s_busy <= 1'b1;
        shadow <= {4{8'd131}};
        f_idx <= 8'd131;
        ef = '0;
        foreach (eb[k]) begin
            pulse(7'(1 << k));
            ef[eb[k]] = 1'b1;
            rd(OFS_ERR_FLAGS, ef);
        end
        bus(1'b1, OFS_ERR_FLAGS, 32'h0);
        rd(OFS_ERR_FLAGS, ef);
        bus(1'b1, OFS_ERR_FLAGS, 32'h4000);
        rd(OFS_ERR_FLAGS, ef & 16'hBFFF);
        bus(1'b1, OFS_ERR_FLAGS, 32'hFFFF);
        cmd_pend <= 1'b0;
        s_busy <= 1'b0;
        pulse(7'h70);
        rd(OFS_ERR_FLAGS, 16'h0000);
        f_idx <= 8'd132;
        pulse(7'h40);
        rd(OFS_ERR_FLAGS, 16'h0200);
        bus(1'b1, OFS_ERR_FLAGS, 32'hFFFF);
        shadow <= {8'd131, 8'd132, 8'd131, 8'd131};
        @(posedge ref_clk);
        shadow <= {4{8'd131}};
        rd(OFS_ERR_FLAGS, 16'h0200);
        bus(1'b1, OFS_IRQ_CLEAR, 32'h3);
        rd(OFS_IRQ_STATUS, 16'h0000);
        bus(1'b1, OFS_GLOBAL_EN, 32'h1);
        @(negedge ref_clk);
        cmp_lvl(1'b1, h_irq);
        rd(OFS_IRQ_STATUS, 16'h0002);
        bus(1'b1, OFS_IRQ_ENABLE, 32'h2);
        @(negedge ref_clk);
        cmp_lvl(1'b1, irq);
        bus(1'b1, OFS_IRQ_ENABLE, 32'h1);
        @(negedge ref_clk);
        cmp_lvl(1'b0, irq);
        bus(1'b1, OFS_ERR_FLAGS, 32'hFFFF);
        bus(1'b1, OFS_IRQ_CLEAR, 32'h2);
        bus(1'b1, OFS_IRQ_ENABLE, 32'h2);
        @(negedge ref_clk);
        cmp_lvl(1'b0, h_irq);
        cmp_lvl(1'b0, irq);
        end_of_test();
    end
endmodule : protocol_irq_enable_and_host_error_flags_test
`default_nettype wire
